// [core/ss_adc_pkg.sv]
package ss_adc_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int ACQ_TIME_NS = 40000;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_TIME_NS = 350000;
  localparam int COUNT_STEPS = 256;
  localparam int TICK_CYCLES = RAMP_TIME_NS / (COUNT_STEPS * CLK_PERIOD_NS);
  localparam int TIMEOUT_TICKS = 384;
  localparam int SEL_W = 3;
  localparam int CNT_W = 8;
  localparam int DIV_STEPS = 17;
  localparam logic [2:0] SEL_ZERO = 3'h0;
  localparam logic [2:0] SEL_FULL = 3'h7;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [7:0] FULL_RST = 8'hFF;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACQ  = 4'b0010,
    ST_RAMP = 4'b0100,
    ST_CORR = 4'b1000
  } ctl_state_t;

  typedef enum logic [1:0] {
    DV_IDLE = 2'b01,
    DV_RUN  = 2'b10
  } div_state_t;
endpackage : ss_adc_pkg

// [core/ramp_corrector.sv]
`timescale 1ns/1ps
module ramp_corrector (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [ss_adc_pkg::CNT_W-1:0] raw,
  input wire logic [ss_adc_pkg::CNT_W-1:0] zero,
  input wire logic [ss_adc_pkg::CNT_W-1:0] full,
  output logic done,
  output logic [ss_adc_pkg::CNT_W-1:0] result
);
  import ss_adc_pkg::*;

  localparam logic [4:0] STEP_LAST = 5'(DIV_STEPS - 1);

  div_state_t state_ff;
  logic [7:0] den_ff;
  logic [8:0] rem_ff;
  logic [16:0] quo_ff;
  logic [4:0] step_ff;
  logic [15:0] num;
  logic [7:0] den;
  logic [8:0] trial;
  logic fits;
  logic [8:0] nxt_rem;
  logic [16:0] nxt_quo;
  logic [16:0] ref_q;
  logic [7:0] ref_ff;

  // zero-corrected count times 256, divisor is one byte
  always_comb begin
    num = (raw > zero) ? {8'(raw - zero), 8'h00} : 16'h0000;
    den = 8'(full - zero);
  end

  always_comb begin
    trial = {rem_ff[7:0], quo_ff[16]};
    fits = (trial >= {1'b0, den_ff});
    nxt_rem = fits ? 9'(trial - {1'b0, den_ff}) : trial;
    nxt_quo = {quo_ff[15:0], fits};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= DV_IDLE;
      step_ff <= 5'h00;
    end else begin
      case (state_ff)
        DV_IDLE: begin
          step_ff <= 5'h00;
          if (go) begin
            state_ff <= DV_RUN;
          end
        end
        DV_RUN: begin
          step_ff <= 5'(step_ff + 5'h01);
          if (step_ff == STEP_LAST) begin
            state_ff <= DV_IDLE;
          end
        end
        default: state_ff <= DV_IDLE;
      endcase
    end
  end

  // 17-bit restoring divide; adding half the divisor first rounds the quotient
  always_ff @(posedge clk) begin
    if (reset) begin
      den_ff <= 8'h00;
      rem_ff <= 9'h000;
      quo_ff <= 17'h00000;
    end else if (state_ff == DV_IDLE && go) begin
      den_ff <= den;
      rem_ff <= 9'h000;
      quo_ff <= {1'b0, num} + {10'h000, den[7:1]};
    end else if (state_ff == DV_RUN) begin
      rem_ff <= nxt_rem;
      quo_ff <= nxt_quo;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      done <= 1'b0;
      result <= 8'h00;
    end else begin
      done <= (state_ff == DV_RUN && step_ff == STEP_LAST);
      if (state_ff == DV_RUN && step_ff == STEP_LAST) begin
        result <= (nxt_quo[16:8] != 9'h000) ? COUNT_MAX : nxt_quo[7:0];
      end
    end
  end

  // reference result for checking only
  always_comb begin
    ref_q = (den == 8'h00) ? 17'h1FFFF :
            17'(({1'b0, num} + {10'h000, den[7:1]}) / {9'h000, den});
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ref_ff <= 8'h00;
    end else if (state_ff == DV_IDLE && go) begin
      ref_ff <= (ref_q[16:8] != 9'h000) ? COUNT_MAX : ref_q[7:0];
    end
  end

  property p_quot;
    @(posedge clk) disable iff (reset)
    done |-> result == ref_ff;
  endproperty
  a_quot: assert property (p_quot) else $error("rounded correction wrong");

  property p_latency;
    @(posedge clk) disable iff (reset)
    (state_ff == DV_IDLE && go) |-> !done [*8] ##11 done;
  endproperty
  a_latency: assert property (p_latency) else $error("divide not done in 18");
endmodule : ramp_corrector

// [core/ss_adc_ctl.sv]
`timescale 1ns/1ps
// How it works
// - hold ramp_go low for acquisition interval
// - count from ramp_go rise to comparator fall
// - counter increments each tick; comparator checked every clock
// - comparator fall ends measurement like interrupt
// - only five pins: select, ramp_go, comparator
// - double precision rounded correction arithmetic
// - zero-corrected count multiplied by 256
// - divisor full minus zero fits byte
module ss_adc_ctl #(
  parameter int ACQ_CYC = ss_adc_pkg::ACQ_CYCLES,
  parameter int TICK_CYC = ss_adc_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic conv_start,
  input wire logic [ss_adc_pkg::SEL_W-1:0] conv_chan,
  input wire logic comp_done,
  output logic [ss_adc_pkg::SEL_W-1:0] channel_sel,
  output logic ramp_go,
  output logic busy,
  output logic conv_done,
  output logic timeout_err,
  output logic [ss_adc_pkg::CNT_W-1:0] raw_count,
  output logic [ss_adc_pkg::CNT_W-1:0] result,
  output logic [ss_adc_pkg::CNT_W-1:0] zero_count,
  output logic [ss_adc_pkg::CNT_W-1:0] full_scale_count
);
  import ss_adc_pkg::*;

  localparam logic [13:0] ACQ_LAST = 14'(ACQ_CYC - 1);
  localparam logic [8:0] TICK_LAST = 9'(TICK_CYC - 1);
  localparam logic [8:0] TO_LAST = 9'(TIMEOUT_TICKS - 1);

  ctl_state_t state_ff;
  logic comp_meta_ff;
  logic comp_sync_ff;
  logic comp_prev_ff;
  logic [13:0] acq_cnt_ff;
  logic [8:0] tick_cnt_ff;
  logic [8:0] ramp_cnt_ff;
  logic corr_go_ff;
  logic corr_done;
  logic [7:0] corr_result;
  logic tick;
  logic comp_fall;
  logic ramp_timeout;
  logic [7:0] raw_sat;

  // comparator pin is asynchronous
  always_ff @(posedge clk) begin
    if (reset) begin
      comp_meta_ff <= 1'b1;
      comp_sync_ff <= 1'b1;
      comp_prev_ff <= 1'b1;
    end else begin
      comp_meta_ff <= comp_done;
      comp_sync_ff <= comp_meta_ff;
      comp_prev_ff <= comp_sync_ff;
    end
  end

  always_comb begin
    tick = (state_ff == ST_RAMP) && (tick_cnt_ff == TICK_LAST);
    comp_fall = comp_prev_ff & ~comp_sync_ff;
    ramp_timeout = tick && (ramp_cnt_ff == TO_LAST) && !comp_fall;
    raw_sat = (ramp_cnt_ff > 9'h0FF) ? COUNT_MAX : ramp_cnt_ff[7:0];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (conv_start) begin
            state_ff <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (acq_cnt_ff == ACQ_LAST) begin
            state_ff <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (comp_fall) begin
            state_ff <= ST_CORR;
          end else if (ramp_timeout) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_CORR: begin
          if (corr_done) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // five pins only: three select lines, ramp_go out, comparator in
  always_ff @(posedge clk) begin
    if (reset) begin
      channel_sel <= SEL_ZERO;
      ramp_go <= 1'b0;
    end else begin
      if (state_ff == ST_IDLE && conv_start) begin
        channel_sel <= conv_chan;
      end
      if (state_ff == ST_ACQ && acq_cnt_ff == ACQ_LAST) begin
        ramp_go <= 1'b1;
      end else if (state_ff != ST_RAMP || comp_fall || ramp_timeout) begin
        ramp_go <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acq_cnt_ff <= 14'h0000;
    end else if (state_ff == ST_ACQ) begin
      acq_cnt_ff <= 14'(acq_cnt_ff + 14'h0001);
    end else begin
      acq_cnt_ff <= 14'h0000;
    end
  end

  // tick divider and ramp counter
  always_ff @(posedge clk) begin
    if (reset) begin
      tick_cnt_ff <= 9'h000;
      ramp_cnt_ff <= 9'h000;
    end else begin
      if (state_ff != ST_RAMP || tick) begin
        tick_cnt_ff <= 9'h000;
      end else begin
        tick_cnt_ff <= 9'(tick_cnt_ff + 9'h001);
      end
      if (state_ff == ST_IDLE) begin
        ramp_cnt_ff <= 9'h000;
      end else if (tick && !comp_fall && !ramp_timeout) begin
        ramp_cnt_ff <= 9'(ramp_cnt_ff + 9'h001);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      raw_count <= 8'h00;
      zero_count <= ZERO_RST;
      full_scale_count <= FULL_RST;
      corr_go_ff <= 1'b0;
    end else begin
      corr_go_ff <= (state_ff == ST_RAMP) && comp_fall;
      if (state_ff == ST_RAMP && comp_fall) begin
        raw_count <= raw_sat;
        if (channel_sel == SEL_ZERO) begin
          zero_count <= raw_sat;
        end
        if (channel_sel == SEL_FULL) begin
          full_scale_count <= raw_sat;
        end
      end
    end
  end

  ramp_corrector u_corr (
    .clk(clk),
    .reset(reset),
    .go(corr_go_ff),
    .raw(raw_count),
    .zero(zero_count),
    .full(full_scale_count),
    .done(corr_done),
    .result(corr_result)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      result <= 8'h00;
      conv_done <= 1'b0;
      busy <= 1'b0;
      timeout_err <= 1'b0;
    end else begin
      conv_done <= (state_ff == ST_CORR && corr_done) || (state_ff == ST_RAMP && ramp_timeout);
      if (state_ff == ST_CORR && corr_done) begin
        result <= corr_result;
      end
      if (state_ff == ST_IDLE && conv_start) begin
        busy <= 1'b1;
      end else if ((state_ff == ST_CORR && corr_done) || (state_ff == ST_RAMP && ramp_timeout)) begin
        busy <= 1'b0;
      end
      if (state_ff == ST_RAMP && ramp_timeout) begin
        timeout_err <= 1'b1;
      end else if (state_ff == ST_IDLE && conv_start) begin
        timeout_err <= 1'b0;
      end
    end
  end

  property p_acq_hold;
    @(posedge clk) disable iff (reset)
    $rose(ramp_go) |-> $past(acq_cnt_ff) == ACQ_LAST && $past(state_ff) == ST_ACQ;
  endproperty
  a_acq_hold: assert property (p_acq_hold) else $error("ramp_go rose early");

  property p_sel_stable;
    @(posedge clk) disable iff (reset)
    (state_ff != ST_IDLE && $past(state_ff) != ST_IDLE) |-> $stable(channel_sel);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("select moved mid conversion");

  property p_stop_on_fall;
    @(posedge clk) disable iff (reset)
    (state_ff == ST_RAMP && comp_fall) |=> state_ff == ST_CORR && !ramp_go
      && raw_count == $past(raw_sat);
  endproperty
  a_stop_on_fall: assert property (p_stop_on_fall) else $error("fall did not stop count");

  property p_go_in_ramp;
    @(posedge clk) disable iff (reset)
    (state_ff == ST_RAMP) |-> ramp_go;
  endproperty
  a_go_in_ramp: assert property (p_go_in_ramp) else $error("ramp_go low in ramp");

  property p_count_inc;
    @(posedge clk) disable iff (reset)
    (tick && !comp_fall && !ramp_timeout) |=> ramp_cnt_ff == 9'($past(ramp_cnt_ff) + 9'h001);
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("ramp count missed a tick");

  property p_timeout;
    @(posedge clk) disable iff (reset)
    ramp_timeout |=> timeout_err && conv_done && state_ff == ST_IDLE && !ramp_go;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not reported");

  property p_done_bound;
    @(posedge clk) disable iff (reset)
    $rose(state_ff == ST_CORR) |-> ##[1:24] conv_done;
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("correction did not finish");

  property p_cal_zero;
    @(posedge clk) disable iff (reset)
    (state_ff == ST_RAMP && comp_fall && channel_sel == SEL_ZERO) |=> zero_count == raw_count;
  endproperty
  a_cal_zero: assert property (p_cal_zero) else $error("zero count not stored");
endmodule : ss_adc_ctl

// [verif/ss_adc_dev_model.sv]
`timescale 1ns/1ps
module ss_adc_dev_model #(
  parameter int ZERO_LVL = 2,
  parameter int FULL_LVL = 22,
  parameter int TICK = ss_adc_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic comp_stuck,
  input wire logic [ss_adc_pkg::SEL_W-1:0] channel_sel,
  input wire logic ramp_go,
  input wire logic [5:0][7:0] analog_inputs,
  output logic comp_done
);
  import ss_adc_pkg::*;
  logic [7:0] held;
  int cnt;

  initial begin
    comp_done = 1'b1;
    held = 8'h00;
    cnt = 0;
  end

  // levels are in counter ticks; a half tick keeps the fall clear of a tick boundary
  // comp_stuck keeps the comparator high so only the timeout can end the ramp
  always @(posedge clk) begin
    if (ramp_go !== 1'b1) begin
      cnt <= 0;
      comp_done <= 1'b1;
      case (channel_sel)
        3'h0: held <= 8'(ZERO_LVL);
        3'h7: held <= 8'(FULL_LVL);
        default: held <= analog_inputs[int'(channel_sel) - 1];
      endcase
    end else if (!comp_stuck && cnt >= int'(held) * TICK + TICK / 2) begin
      comp_done <= 1'b0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : ss_adc_dev_model

// [verif/single_slope_adc_ramp_timing_tb.sv]
`timescale 1ns/1ps
module single_slope_adc_ramp_timing_tb;
  import ss_adc_pkg::*;
  localparam int ACQ_SIM = 20;
  localparam int TICK_SIM = 40;
  localparam int ZL = 2;
  localparam int FL = 22;
  typedef struct {
    logic [2:0] chan;
    logic [7:0] raw;
    logic [7:0] res;
    logic [7:0] zc;
    logic [7:0] fc;
    logic to;
  } exp_t;
  logic clk, reset, conv_start, comp_done, ramp_go, busy, conv_done, timeout_err;
  logic comp_stuck;
  logic [2:0] conv_chan, channel_sel;
  logic [7:0] raw_count, result, zero_count, full_scale_count;
  logic [5:0][7:0] lvl;
  exp_t q[$];
  int failures = 0;
  int tests_run = 0;
  int zc = 0;
  int fc = 255;
  int last_raw = 0;
  int last_res = 0;
  int acq_cnt = 0;
  int cycles = 0;
  logic ramp_prev = 1'b0;

  ss_adc_ctl #(.ACQ_CYC(ACQ_SIM), .TICK_CYC(TICK_SIM)) u_dut (.clk(clk), .reset(reset),
    .conv_start(conv_start), .conv_chan(conv_chan), .comp_done(comp_done),
    .channel_sel(channel_sel), .ramp_go(ramp_go), .busy(busy), .conv_done(conv_done),
    .timeout_err(timeout_err), .raw_count(raw_count), .result(result),
    .zero_count(zero_count), .full_scale_count(full_scale_count));

  ss_adc_dev_model #(.ZERO_LVL(ZL), .FULL_LVL(FL), .TICK(TICK_SIM)) u_dev (.clk(clk),
    .comp_stuck(comp_stuck), .channel_sel(channel_sel), .ramp_go(ramp_go),
    .analog_inputs(lvl), .comp_done(comp_done));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  function automatic logic [7:0] corr(input int r, input int z, input int f);
    int v;
    if (r <= z) return 8'h00;
    if (f <= z) return 8'hFF;
    v = ((r - z) * 512 + (f - z)) / (2 * (f - z));
    return (v > 255) ? 8'hFF : v[7:0];
  endfunction : corr

  task automatic wait_idle();
    @(posedge clk);
    #1;
    while (busy !== 1'b0) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_idle

  // waits for idle, notes the expectation, then pulses the request for one cycle
  // a stuck comparator aborts: counts and result keep their last values
  task automatic convert(input logic [2:0] ch);
    exp_t e;
    int r;
    wait_idle();
    r = (ch == 3'h0) ? ZL : (ch == 3'h7) ? FL : int'(lvl[int'(ch) - 1]);
    if (comp_stuck) begin
      e = '{ch, 8'(last_raw), 8'(last_res), 8'(zc), 8'(fc), 1'b1};
    end else begin
      if (ch == 3'h0) zc = r;
      if (ch == 3'h7) fc = r;
      last_raw = r;
      last_res = int'(corr(r, zc, fc));
      e = '{ch, 8'(r), 8'(last_res), 8'(zc), 8'(fc), 1'b0};
    end
    q.push_back(e);
    conv_start = 1'b1;
    conv_chan = ch;
    @(posedge clk);
    #1;
    conv_start = 1'b0;
  endtask : convert

  always @(negedge clk) begin
    exp_t e;
    if (busy === 1'b1 && ramp_go === 1'b0) acq_cnt++;
    if (ramp_go === 1'b1 && ramp_prev === 1'b0) begin
      chk(8'(acq_cnt >= ACQ_SIM), 8'h01);
      if (q.size() > 0) chk(8'(channel_sel), 8'(q[0].chan));
    end
    ramp_prev = ramp_go;
    if (conv_done === 1'b1) begin
      acq_cnt = 0;
      if (q.size() == 0) begin
        chk(8'h01, 8'h00);
      end else begin
        e = q.pop_front();
        chk(8'(channel_sel), 8'(e.chan));
        chk(raw_count, e.raw);
        chk(result, e.res);
        chk(zero_count, e.zc);
        chk(full_scale_count, e.fc);
        chk(8'(ramp_go), 8'h00);
        chk(8'(timeout_err), 8'(e.to));
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 40000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    reset = 1'b1;
    conv_start = 1'b0;
    conv_chan = 3'h0;
    comp_stuck = 1'b0;
    lvl = '0;
    void'($urandom(32'hd2bf));
    for (int i = 1; i < 5; i++) lvl[i] = 8'(3 + $urandom % 18);
    lvl[0] = 8'h00;
    lvl[5] = 8'(FL);
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    chk(zero_count, 8'h00);
    chk(full_scale_count, 8'hFF);
    chk({5'h00, busy, ramp_go, conv_done}, 8'h00);
    convert(3'h3);
    convert(3'h0);
    convert(3'h7);
    repeat (30) @(posedge clk);
    #1;
    conv_start = 1'b1;
    conv_chan = 3'h5;
    @(posedge clk);
    #1;
    conv_start = 1'b0;
    for (int c = 1; c < 7; c++) convert(3'(c));
    wait_idle();
    comp_stuck = 1'b1;
    convert(3'h2);
    wait_idle();
    comp_stuck = 1'b0;
    convert(3'h3);
    while (q.size() != 0) @(posedge clk);
    repeat (5) @(posedge clk);
    final_report();
  end
endmodule : single_slope_adc_ramp_timing_tb
